/* common/vip_defines.vh */
// Register map, field positions and reset values of the vectored prioritizer
`ifndef VIP_DEFINES_VH
`define VIP_DEFINES_VH
`define VIP_ADDR_CTRL 4'h0
`define VIP_ADDR_MASK 4'h1
`define VIP_ADDR_SWREQ 4'h2
`define VIP_ADDR_PEND 4'h3
`define VIP_ADDR_RESULT 4'h4
`define VIP_ADDR_INTSTAT 4'h5
`define VIP_ADDR_INTMASK 4'h6
`define VIP_ADDR_SHADOW 4'h7
`define VIP_ADDR_CONFIG 4'h8
`define VIP_ADDR_SHADOW_HI 4'h9
`define VIP_CTRL_ENABLE 0
`define VIP_CTRL_EXC_LVL 1
`define VIP_CTRL_ERR_LVL 2
`define VIP_CTRL_BOOT_SEL 3
`define VIP_CTRL_SPEC_VEC 4
`define VIP_CTRL_SPACING_LSB 8
`define VIP_CTRL_TIMER_LSB 16
`define VIP_CFG_VEC_SUP 0
`define VIP_CFG_EXT_CTRL 1
`define VIP_CTRL_RESET 32'h0000_0006
`define VIP_MASK_RESET 10'h000
`define VIP_SPACING_W 5
`define VIP_TIMER_W 3
`define VIP_TIMER_RESET 3'h7
`define VIP_ST_INT 0
`define VIP_ST_VEC 1
`define VIP_ST_MODE 2
`endif

/* dv/test_vectored_interrupt_prioritizer.sv */
// Bench: reference model of the prioritizer against the design
`timescale 1ns/1ps
`include "vip_defines.vh"
module test_vectored_interrupt_prioritizer;
  logic mclk = 1'h0, resetn = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
  logic ext = 1'h0, tmr = 1'h0, avs_waitrequest, int_signal, vectored_mode, irq;
  logic [3:0] avs_address = 4'h0, vector_number, shadow_set;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [7:0] lines = 8'h00, hw_request;
  logic [31:0] bad [6] = '{32'h113, 32'h115, 32'h110, 32'h119, 32'h101, 32'h11};
  integer mismatches = 0, total_checks = 0, i, k, v, p;
  initial forever #12.5 mclk = ~mclk;
  vip_prioritizer DUT (.mclk, .resetn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .hw_request,
    .ext_controller_present(ext), .int_signal, .vector_number, .shadow_set,
    .vectored_mode, .irq);
  vip_src SRC (.mclk, .lines, .timer_tick(tmr), .hw_request);
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %0t got %h want %h", $time, s, e);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    integer n;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 64);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    if (avs_waitrequest !== 1'h0) begin
      mismatches++;
      report_and_stop;
    end
  endtask
  task run(input integer h, s, m, t, en);
    bus(1'h1, `VIP_ADDR_MASK, m);
    bus(1'h1, `VIP_ADDR_SWREQ, s);
    lines <= h[7:0];
    tmr <= t[0];
    repeat (6) @(posedge mclk);
    p = ((h | t << 5) << 2 | s) & m;
    v = -1;
    for (i = 0; i < 10; i++) if (p >> i & 1) v = i;
    en = en && v >= 0;
    bus(1'h0, `VIP_ADDR_RESULT, 0);
    chk(q[4], en);
    chk(int_signal, en);
    if (en) chk(vector_number, v);
    if (en) chk(shadow_set, v);
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'hFA28));
    repeat (20) @(posedge mclk);
    resetn <= 1'h1;
    bus(1'h0, `VIP_ADDR_CONFIG, 0);
    chk(q[1:0], 2'h1);
    bus(1'h0, `VIP_ADDR_CTRL, 0);
    chk(q & 32'h7001F, 32'h70006);
    bus(1'h0, 4'hF, 0);
    chk(q, 0);
    bus(1'h1, `VIP_ADDR_SHADOW, 32'h76543210);
    bus(1'h1, `VIP_ADDR_SHADOW_HI, 32'h98);
    bus(1'h1, `VIP_ADDR_INTMASK, 1);
    bus(1'h1, `VIP_ADDR_CTRL, 32'h111);
    $display("setup done");
    for (k = 0; k < 10; k++)
      run(k > 1 ? 1 << k - 2 : 0, k < 2 ? 1 << k : 0, 32'h3FF, 0, 1);
    chk(irq, 1);
    bus(1'h1, `VIP_ADDR_INTMASK, 0);
    run(0, 0, 32'h3FF, 0, 1);
    bus(1'h1, `VIP_ADDR_INTSTAT, 7);
    bus(1'h0, `VIP_ADDR_INTSTAT, 0);
    chk(q[0], 0);
    run(32'h80, 0, 32'h3FF, 0, 1);
    chk(irq, 0);
    bus(1'h1, `VIP_ADDR_INTMASK, 1);
    repeat (2) @(posedge mclk);
    chk(irq, 1);
    $display("vectors and irq done");
    for (k = 0; k < 6; k++) begin
      bus(1'h1, `VIP_ADDR_CTRL, bad[k]);
      run(32'hFF, 3, 32'h3FF, 1, 0);
    end
    bus(1'h1, `VIP_ADDR_CTRL, 32'h111);
    ext <= 1'h1;
    run(32'hFF, 3, 32'h3FF, 1, 0);
    chk(vectored_mode, 0);
    ext <= 1'h0;
    $display("mode gating done");
    for (k = 0; k < 60; k++)
      run($urandom & 255, $urandom & 3, $urandom & 1023, $urandom & 1, 1);
    $display("random done");
    report_and_stop;
  end
endmodule // test_vectored_interrupt_prioritizer

/* dv/vip_chk.sv */
// Port assertions for the vectored prioritizer
`timescale 1ns/1ps
module vip_chk #(
  parameter NUM_HW = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Interrupt side
  input wire logic [NUM_HW-1:0] hw_request,
  input wire logic int_signal,
  input wire logic [3:0] vector_number,
  input wire logic vectored_mode
);
  logic [NUM_HW-1:0] hw_d1, hw_d2, hw_d3;
  // Same latency as the input sync plus output stage
  always @(posedge mclk) begin
    hw_d1 <= hw_request;
    hw_d2 <= hw_d1;
    hw_d3 <= hw_d2;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  mode_gate_a:
    assert property (!vectored_mode |-> !int_signal) else $error("int off mode");
  vec_range_a:
    assert property (int_signal |-> vector_number <= 4'h9) else $error("vector");
  hw_source_a:
    assert property (int_signal && vector_number > 4'h1
      |-> hw_d3[vector_number - 4'h2]) else $error("vector without line");
  bus_ack_a:
    assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("no ack");
  ack_pulse_a:
    assert property (!avs_waitrequest |=> avs_waitrequest) else $error("ack");
  idle_wait_a:
    assert property (!avs_read && !avs_write |=> avs_waitrequest)
      else $error("stray ack");
  vectored_support_flag_read_a:
    assert property (avs_read && !avs_waitrequest && avs_address == 4'h8
      |-> avs_readdata[0]) else $error("support bit");
  timer_line_a:
    assert property (avs_read && !avs_waitrequest && avs_address == 4'h0
      |-> avs_readdata[18:16] == 3'h7) else $error("timer field");
endmodule // vip_chk
bind vip_prioritizer vip_chk #(.NUM_HW(NUM_HW)) chk_i (.*);

/* dv/vip_src.sv */
// Hardware interrupt sources outside the core
`timescale 1ns/1ps
module vip_src (
  // Clock
  input wire logic mclk,
  // Requests from the bench
  input wire logic [7:0] lines,
  input wire logic timer_tick,
  // Lines into the core
  output logic [7:0] hw_request
);
  // Timer shares hardware line 5; the timer field names line 7
  always @(posedge mclk) hw_request <= lines | {2'h0, timer_tick, 5'h00};
endmodule // vip_src

/* rtl/vip_prioritizer.v */
// Vectored interrupt prioritizer with Avalon-MM register slave
`timescale 1ns/1ps
`include "vip_defines.vh"
module vip_prioritizer #(
  parameter NUM_HW = 8,
  parameter SS_W = 4
) (
  // Clock and reset
  input wire mclk,
  input wire resetn,
  // Avalon-MM slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Hardware interrupt lines, asynchronous
  input wire [NUM_HW-1:0] hw_request,
  // Static system strap
  input wire ext_controller_present,
  // Pipeline side
  output reg int_signal,
  output reg [3:0] vector_number,
  output reg [SS_W-1:0] shadow_set,
  output reg vectored_mode,
  // Interrupt
  output reg irq
);

  // Vectored support is always built in
  localparam VECTORED_SUPPORT_FLAG = 1'b1;

  // Limitations:
  //   Only the vectored mode is built; outside it the pipeline
  //   sees no interrupt at all, so compatibility dispatch must be
  //   done by other logic.
  //   Handler address arithmetic is left to the pipeline; only
  //   the vector number and its shadow set leave this block.
  //   Request pins add two cycles of latency through the
  //   synchronisers; software requests add none.

  // Two-flop synchronisers for the request pins and the strap
  reg [NUM_HW-1:0] hw_meta;
  reg [NUM_HW-1:0] hw_sync;
  reg [1:0] eic_meta;

  // Control word fields, written by software except the timer line field
  reg global_int_enable;
  reg exception_level_flag;
  reg error_level_flag;
  reg boot_vector_select;
  reg special_int_vector;
  reg [`VIP_SPACING_W-1:0] vector_spacing;
  reg [`VIP_TIMER_W-1:0] timer_line_field;

  // Request masking and software requests
  reg [9:0] mask_bits;
  reg [1:0] sw_request;

  // Shadow set per vector, SS_W bits each, vector 0 lowest
  reg [SS_W*10-1:0] shadow_map;

  // Sticky event status and its mask
  reg [2:0] int_status;
  reg [2:0] int_mask;

  // Last cycle's result, for the edge events
  reg prev_int;
  reg [3:0] prev_vec;
  reg prev_mode;

  // Bus handshake: at most one access in flight
  reg ack_pending;

  // Request path
  wire [9:0] pending_bits;
  wire [9:0] masked_req;
  wire int_enabled;
  wire mode_ok;
  wire next_int;
  wire [3:0] next_vec;

  // Status path and bus
  wire [2:0] events;
  wire [2:0] next_status;
  wire access;

  // Highest set bit wins; 9..2 are hardware, 1..0 software
  // Upward scan, so a later set bit overrides an earlier one.
  // Returns 0 with no request; the caller gates on the OR.
  function [3:0] prio_encode;
    input [9:0] req;
    integer i;
    begin
      prio_encode = 4'h0;
      for (i = 0; i < 10; i = i + 1) begin
        if (req[i]) begin
          prio_encode = i[3:0];
        end
      end
    end
  endfunction

  // Synchroniser for asynchronous pins
  // Only the second stage is read; the first may be metastable.
  // Each line is synchronised alone: they are independent levels.
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hw_meta <= {NUM_HW{1'b0}};
      hw_sync <= {NUM_HW{1'b0}};
      eic_meta <= 2'h0;
    end else begin
      hw_meta <= hw_request;
      hw_sync <= hw_meta;
      eic_meta <= {eic_meta[0], ext_controller_present};
    end
  end

  assign pending_bits = {hw_sync, sw_request};
  assign masked_req = pending_bits & mask_bits;
  assign int_enabled = global_int_enable & ~exception_level_flag &
                       ~error_level_flag;
  // All five conditions at once; any one missing drops the mode
  // and with it the interrupt signal, so a half-programmed control
  // word never dispatches through a vector.
  assign mode_ok = VECTORED_SUPPORT_FLAG & ~eic_meta[1] &
                   (|vector_spacing) & special_int_vector &
                   ~boot_vector_select;
  assign next_int = mode_ok & int_enabled & (|masked_req);
  assign next_vec = prio_encode(masked_req);

  // Sticky events: new interrupt, vector change, mode change
  // Compared against last cycle's result, so each change sets its
  // bit once. A vector change only counts while the signal was
  // already high; the rising signal has its own bit.
  assign events = {mode_ok ^ prev_mode,
                   next_int & (next_vec != prev_vec) & prev_int,
                   next_int & ~prev_int};
  assign access = (avs_read | avs_write) & avs_waitrequest & ~ack_pending;
  // Set wins over the write-one clear
  assign next_status = (int_status &
    ~((access && avs_write && avs_address == `VIP_ADDR_INTSTAT) ?
      avs_writedata[2:0] : 3'h0)) | events;

  // Pipeline outputs
  // All registered: one cycle after a register write, three after
  // a pin change. Vector and shadow set are don't-care while the
  // interrupt signal is low.
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      int_signal <= 1'b0;
      vector_number <= 4'h0;
      shadow_set <= {SS_W{1'b0}};
      vectored_mode <= 1'b0;
      prev_int <= 1'b0;
      prev_vec <= 4'h0;
      prev_mode <= 1'b0;
      int_status <= 3'h0;
      irq <= 1'b0;
    end else begin
      int_signal <= next_int;
      vector_number <= next_vec;
      shadow_set <= shadow_map[next_vec*SS_W +: SS_W];
      vectored_mode <= mode_ok;
      prev_int <= next_int;
      prev_vec <= next_vec;
      prev_mode <= mode_ok;
      int_status <= next_status;
      irq <= |(next_status & int_mask);
    end
  end

  // Avalon slave: one wait cycle, answer on the second edge
  // Register map, word addressed:
  //   0 control: enable, level flags, boot select, special vector,
  //     vector spacing; timer line field read only
  //   1 request mask, one bit per request position
  //   2 software requests, bit 1 above bit 0
  //   3 raw pending requests, hardware above software, read only
  //   4 result: vector, interrupt signal, vectored mode, read only
  //   5 sticky events, write one to clear
  //   6 event mask for the level interrupt
  //   7 shadow sets of vectors seven down to zero
  //   8 configuration, read only
  //   9 shadow sets of vectors nine and eight
  // Unmapped words read zero and ignore writes.
  // A request is taken at an edge with waitrequest high and no
  // answer in flight; waitrequest falls for the next cycle, with
  // read data valid then. The cycle after an answer always waits,
  // but ack_pending is clear again by then, so a master holding its
  // request one edge late is taken again and served twice.
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      ack_pending <= 1'b0;
      global_int_enable <= 1'b0;
      exception_level_flag <= 1'b1;
      error_level_flag <= 1'b1;
      boot_vector_select <= 1'b0;
      special_int_vector <= 1'b0;
      // Both level flags set: no interrupt until software clears
      vector_spacing <= {`VIP_SPACING_W{1'b0}};
      timer_line_field <= `VIP_TIMER_RESET;
      mask_bits <= `VIP_MASK_RESET;
      sw_request <= 2'h0;
      shadow_map <= {(SS_W*10){1'b0}};
      int_mask <= 3'h0;
    end else begin
      avs_waitrequest <= 1'b1;
      ack_pending <= 1'b0;
      if (access) begin
        avs_waitrequest <= 1'b0;
        ack_pending <= 1'b1;
        avs_readdata <= 32'h0000_0000;
        if (avs_address == `VIP_ADDR_CTRL) begin
          if (avs_write) begin
            global_int_enable <= avs_writedata[`VIP_CTRL_ENABLE];
            exception_level_flag <= avs_writedata[`VIP_CTRL_EXC_LVL];
            error_level_flag <= avs_writedata[`VIP_CTRL_ERR_LVL];
            boot_vector_select <= avs_writedata[`VIP_CTRL_BOOT_SEL];
            special_int_vector <= avs_writedata[`VIP_CTRL_SPEC_VEC];
            vector_spacing <=
              avs_writedata[`VIP_CTRL_SPACING_LSB +: `VIP_SPACING_W];
          end
          // Read back shows the value before a write in this access
          avs_readdata[`VIP_CTRL_ENABLE] <= global_int_enable;
          avs_readdata[`VIP_CTRL_EXC_LVL] <= exception_level_flag;
          avs_readdata[`VIP_CTRL_ERR_LVL] <= error_level_flag;
          avs_readdata[`VIP_CTRL_BOOT_SEL] <= boot_vector_select;
          avs_readdata[`VIP_CTRL_SPEC_VEC] <= special_int_vector;
          avs_readdata[`VIP_CTRL_SPACING_LSB +: `VIP_SPACING_W] <=
            vector_spacing;
          // Timer merge point is set by system wiring, read only
          avs_readdata[`VIP_CTRL_TIMER_LSB +: `VIP_TIMER_W] <=
            timer_line_field;
        end else if (avs_address == `VIP_ADDR_MASK) begin
          if (avs_write) begin
            mask_bits <= avs_writedata[9:0];
          end
          avs_readdata[9:0] <= mask_bits;
        end else if (avs_address == `VIP_ADDR_SWREQ) begin
          if (avs_write) begin
            sw_request <= avs_writedata[1:0];
          end
          avs_readdata[1:0] <= sw_request;
        end else if (avs_address == `VIP_ADDR_PEND) begin
          avs_readdata[9:0] <= pending_bits;
        end else if (avs_address == `VIP_ADDR_RESULT) begin
          avs_readdata[3:0] <= vector_number;
          avs_readdata[4] <= int_signal;
          avs_readdata[5] <= vectored_mode;
        end else if (avs_address == `VIP_ADDR_INTSTAT) begin
          avs_readdata[2:0] <= int_status;
        end else if (avs_address == `VIP_ADDR_INTMASK) begin
          if (avs_write) begin
            int_mask <= avs_writedata[2:0];
          end
          avs_readdata[2:0] <= int_mask;
        end else if (avs_address == `VIP_ADDR_SHADOW) begin
          // Ten sets do not fit one word: vectors 7..0 live here
          if (avs_write) begin
            shadow_map[SS_W*8-1:0] <= avs_writedata[SS_W*8-1:0];
          end
          avs_readdata[SS_W*8-1:0] <= shadow_map[SS_W*8-1:0];
        end else if (avs_address == `VIP_ADDR_CONFIG) begin
          avs_readdata[`VIP_CFG_VEC_SUP] <= VECTORED_SUPPORT_FLAG;
          avs_readdata[`VIP_CFG_EXT_CTRL] <= eic_meta[1];
        end else if (avs_address == `VIP_ADDR_SHADOW_HI) begin
          // Vectors 9 and 8
          if (avs_write) begin
            shadow_map[SS_W*10-1:SS_W*8] <=
              avs_writedata[SS_W*2-1:0];
          end
          avs_readdata[SS_W*2-1:0] <= shadow_map[SS_W*10-1:SS_W*8];
        end
      end
    end
  end

endmodule // vip_prioritizer
